/* File: rtl/sac_params.svh */
// register addresses, field positions, reset values and counts of the converter control block
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
`define SAC_ADDR_CON1     8'hEF
`define SAC_ADDR_CON2     8'hD8
`define SAC_ADDR_RES_LO   8'hD9
`define SAC_ADDR_RES_HI   8'hDA
`define SAC_ADDR_CAL_OFS  8'hF1
`define SAC_ADDR_CAL_GAIN 8'hF2
`define SAC_BIT_LOW       3'h0
`define SAC_CON1_RST      8'h00
`define SAC_CON2_RST      8'h00
`define SAC_RES_RST       8'h00
`define SAC_RD_IDLE       8'h00
`define SAC_C1_POWER      7
`define SAC_C1_REFSEL     6
`define SAC_C1_DIV_HI     5
`define SAC_C1_DIV_LO     4
`define SAC_C1_ACQ_HI     3
`define SAC_C1_ACQ_LO     2
`define SAC_C1_TMR        1
`define SAC_C1_PIN        0
`define SAC_C2_DONE       7
`define SAC_C2_SPI        6
`define SAC_C2_CONT       5
`define SAC_C2_SINGLE     4
`define SAC_C2_CH_HI      3
`define SAC_C2_CH_LO      0
`define SAC_DIV_CODE8     2'h0
`define SAC_DIV_CODE4     2'h1
`define SAC_DIV_CODE16    2'h2
`define SAC_HALF_DIV8     5'h03
`define SAC_HALF_DIV4     5'h01
`define SAC_HALF_DIV16    5'h07
`define SAC_HALF_SPARE    5'h0F
`define SAC_ACQ_BASE      3'h1
`define SAC_CH_SHARED0    4'h4
`define SAC_CH_SHARED1    4'h5
`define SAC_CH_TEMP       4'h8
`define SAC_CH_ANALOG_OUT_ZERO       4'h9
`define SAC_CH_ANALOG_OUT_ONE       4'hA
`define SAC_CH_VREF       4'hB
`define SAC_CH_ANALOG_GROUND_INPUT       4'hC
`define SAC_IN_TEMP       0
`define SAC_IN_ANALOG_OUT_ZERO       1
`define SAC_IN_ANALOG_OUT_ONE       2
`define SAC_IN_VREF       3
`define SAC_IN_ANALOG_GROUND_INPUT       4
`endif

/* File: rtl/sac_pkg.sv */
// types shared by the converter control block
package sac_pkg;
	typedef enum logic [1:0] {SAC_IDLE, SAC_ACQUIRE, SAC_CONVERT, SAC_STORE} sac_phase_t;

	typedef struct packed {
		logic [3:0]  tag;
		logic [11:0] data;
	} sac_result_t;

	typedef struct packed {
		logic        powerUp;
		logic        refExternal;
		logic        trackHold;
		logic        convStart;
		logic [3:0]  channel;
		logic [1:0]  dacRoute;
		logic [4:0]  internalSel;
	} sac_core_ctl_t;

	typedef struct packed {
		logic [7:0]    con1;
		logic [7:0]    con2;
		logic [7:0]    resLo;
		logic [7:0]    resHi;
		logic [7:0]    calOfs;
		logic [7:0]    calGain;
		logic [7:0]    rdData;
		logic          bitRd;
		sac_phase_t    phase;
		logic [4:0]    divCnt;
		logic          adcClk;
		logic [2:0]    acqCnt;
		logic [1:0]    pinSync;
		logic          pinPrev;
		sac_result_t   capture;
		sac_core_ctl_t core;
	} sac_state_t;
endpackage

/* File: rtl/sac_fifo.sv */
// result fifo with registered output stage and back-pressure on both sides
`timescale 1ns/10ps
module sac_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// drain side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [AW:0]                 count;
		logic                        oValid;
		logic [WIDTH-1:0]            oData;
	} sac_fifo_state_t;

	sac_fifo_state_t q;
	sac_fifo_state_t d;
	logic            push;
	logic            pop;

	always_comb begin
		d = q;
		inReady = (q.count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
		push = inValid && inReady;
		pop = (q.count != '0) && (!q.oValid || outReady);
		if (outReady && q.oValid) begin
			d.oValid = 1'b0;
		end
		if (pop) begin
			d.oData = q.mem[q.rdPtr];
			d.oValid = 1'b1;
			d.rdPtr = q.rdPtr + AW'(1);
		end
		if (push) begin
			d.mem[q.wrPtr] = inData;
			d.wrPtr = q.wrPtr + AW'(1);
		end
		d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
		outValid = q.oValid;
		outData = q.oData;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

/* File: rtl/sac_control.sv */
// control, trigger and result logic of the 12-bit successive-approximation converter
// Contract
// - bit-addressable registers accept single-bit access too
// - factory calibration loaded on every reset
// - twelve-bit result, six external channels
// - five internal sources on same select field
// - software single or continuous conversion
// - pin and timer overflow start conversions
// - results stream to serial port unaided
// - channels four/five measure enabled analog outputs
// - result is straight binary code
// - low result register holds bits 7:0
// - high register: tag nibble, top result nibble
// - control bit 7 powers converter
// - control bit 6 selects external reference
// - bits 5:4 pick clock divider
// - bits 3:2 set acquisition clocks
// - bit 1 enables timer overflow trigger
// - bit 0 enables pin rising-edge trigger
// - done flag set hardware, cleared ack/software
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_control #(
	parameter logic [7:0] FACTORY_OFFSET = 8'h00,
	parameter logic [7:0] FACTORY_GAIN   = 8'h80,
	parameter int         FIFO_DEPTH     = 16
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// byte register access
	input  wire logic [7:0]  sfrAddr,
	input  wire logic        sfrWrEn,
	input  wire logic [7:0]  sfrWrData,
	input  wire logic        sfrRdEn,
	output logic [7:0]       sfrRdData,
	// bit register access
	input  wire logic [7:0]  sfrBitAddr,
	input  wire logic        sfrBitWrEn,
	input  wire logic        sfrBitWrVal,
	input  wire logic        sfrBitRdEn,
	output logic             sfrBitRdVal,
	// interrupt vector acknowledge
	input  wire logic        adcIntAck,
	// hardware triggers
	input  wire logic        convertStartPin_n,
	input  wire logic        timerTwoOverflow,
	// analog output enables
	input  wire logic [1:0]  dacEnable,
	// analog core
	input  wire logic        coreDone,
	input  wire logic [11:0] coreResult,
	output logic             adcClk,
	output logic             corePowerUp,
	output logic             coreRefExternal,
	output logic             coreTrackHold,
	output logic             coreConvStart,
	output logic [3:0]       coreChannel,
	output logic [1:0]       coreDacRoute,
	output logic [4:0]       coreInternalSel,
	output logic [7:0]       coreCalOffset,
	output logic [7:0]       coreCalGain,
	// status
	output logic             conversionDone,
	// serial port stream
	output logic [15:0]      spiData,
	output logic             spiValid,
	input  wire logic        spiReady
);
	sac_pkg::sac_state_t q;
	sac_pkg::sac_state_t d;
	logic                adcTick;
	logic                pinEdge;
	logic                startReq;
	logic                fifoInValid;
	logic                fifoInReady;
	logic [7:0]          bitByte;
	logic [3:0]          chan;

	function automatic logic isBitAddr(input logic [7:0] a);
		return a[2:0] == `SAC_BIT_LOW;
	endfunction

	function automatic logic [4:0] divHalf(input logic [1:0] code);
		if (code == `SAC_DIV_CODE8) begin
			return `SAC_HALF_DIV8;
		end else if (code == `SAC_DIV_CODE4) begin
			return `SAC_HALF_DIV4;
		end else if (code == `SAC_DIV_CODE16) begin
			return `SAC_HALF_DIV16;
		end else begin
			return `SAC_HALF_SPARE;
		end
	endfunction

	always_comb begin
		d = q;
		d.core.convStart = 1'b0;
		bitByte = {sfrBitAddr[7:3], `SAC_BIT_LOW};
		chan = q.con2[`SAC_C2_CH_HI:`SAC_C2_CH_LO];

		// converter clock divider, free running
		adcTick = (q.divCnt == 5'h00) && !q.adcClk;
		if (q.divCnt == 5'h00) begin
			d.divCnt = divHalf(q.con1[`SAC_C1_DIV_HI:`SAC_C1_DIV_LO]);
			d.adcClk = ~q.adcClk;
		end else begin
			d.divCnt = q.divCnt - 5'h01;
		end

		// start pin synchroniser and rising edge
		d.pinSync = {q.pinSync[0], convertStartPin_n};
		d.pinPrev = q.pinSync[1];
		pinEdge = q.pinSync[1] && !q.pinPrev;

		// byte writes
		if (sfrWrEn) begin
			if (sfrAddr == `SAC_ADDR_CON1) begin
				d.con1 = sfrWrData;
			end else if (sfrAddr == `SAC_ADDR_CON2) begin
				d.con2 = sfrWrData;
			end else if (sfrAddr == `SAC_ADDR_CAL_OFS) begin
				d.calOfs = sfrWrData;
			end else if (sfrAddr == `SAC_ADDR_CAL_GAIN) begin
				d.calGain = sfrWrData;
			end
		end

		// single-bit writes on bit-addressable registers
		if (sfrBitWrEn && isBitAddr(bitByte)) begin
			if (bitByte == `SAC_ADDR_CON2) begin
				d.con2[sfrBitAddr[2:0]] = sfrBitWrVal;
			end
		end

		// byte reads
		d.rdData = `SAC_RD_IDLE;
		if (sfrRdEn) begin
			if (sfrAddr == `SAC_ADDR_CON1) begin
				d.rdData = q.con1;
			end else if (sfrAddr == `SAC_ADDR_CON2) begin
				d.rdData = q.con2;
			end else if (sfrAddr == `SAC_ADDR_RES_LO) begin
				d.rdData = q.resLo;
			end else if (sfrAddr == `SAC_ADDR_RES_HI) begin
				d.rdData = q.resHi;
			end else if (sfrAddr == `SAC_ADDR_CAL_OFS) begin
				d.rdData = q.calOfs;
			end else if (sfrAddr == `SAC_ADDR_CAL_GAIN) begin
				d.rdData = q.calGain;
			end
		end

		// single-bit reads
		d.bitRd = 1'b0;
		if (sfrBitRdEn && isBitAddr(bitByte)) begin
			if (bitByte == `SAC_ADDR_CON2) begin
				d.bitRd = q.con2[sfrBitAddr[2:0]];
			end
		end

		// flag clear by interrupt vectoring
		if (adcIntAck) begin
			d.con2[`SAC_C2_DONE] = 1'b0;
		end

		// core static controls
		d.core.powerUp = q.con1[`SAC_C1_POWER];
		d.core.refExternal = q.con1[`SAC_C1_REFSEL];

		// conversion triggers
		startReq = q.con2[`SAC_C2_SINGLE] || q.con2[`SAC_C2_CONT];
		if (q.con1[`SAC_C1_TMR] && timerTwoOverflow) begin
			startReq = 1'b1;
		end
		if (q.con1[`SAC_C1_PIN] && pinEdge) begin
			startReq = 1'b1;
		end

		fifoInValid = 1'b0;
		case (q.phase)
			sac_pkg::SAC_IDLE: begin
				d.core.trackHold = 1'b0;
				if (q.con1[`SAC_C1_POWER] && startReq) begin
					d.phase = sac_pkg::SAC_ACQUIRE;
					d.core.trackHold = 1'b1;
					d.acqCnt = {1'b0, q.con1[`SAC_C1_ACQ_HI:`SAC_C1_ACQ_LO]} + `SAC_ACQ_BASE;
					d.core.channel = chan;
					d.capture.tag = chan;
					d.core.dacRoute[0] = (chan == `SAC_CH_SHARED0) && dacEnable[0];
					d.core.dacRoute[1] = (chan == `SAC_CH_SHARED1) && dacEnable[1];
					d.core.internalSel[`SAC_IN_TEMP] = (chan == `SAC_CH_TEMP);
					d.core.internalSel[`SAC_IN_ANALOG_OUT_ZERO] = (chan == `SAC_CH_ANALOG_OUT_ZERO);
					d.core.internalSel[`SAC_IN_ANALOG_OUT_ONE] = (chan == `SAC_CH_ANALOG_OUT_ONE);
					d.core.internalSel[`SAC_IN_VREF] = (chan == `SAC_CH_VREF);
					d.core.internalSel[`SAC_IN_ANALOG_GROUND_INPUT] = (chan == `SAC_CH_ANALOG_GROUND_INPUT);
				end
			end
			sac_pkg::SAC_ACQUIRE: begin
				if (adcTick) begin
					d.acqCnt = q.acqCnt - 3'h1;
					if (q.acqCnt == `SAC_ACQ_BASE) begin
						d.phase = sac_pkg::SAC_CONVERT;
						d.core.trackHold = 1'b0;
						d.core.convStart = 1'b1;
					end
				end
			end
			sac_pkg::SAC_CONVERT: begin
				if (coreDone) begin
					d.capture.data = coreResult;
					d.phase = sac_pkg::SAC_STORE;
				end
			end
			sac_pkg::SAC_STORE: begin
				fifoInValid = q.con2[`SAC_C2_SPI];
				if (!q.con2[`SAC_C2_SPI] || fifoInReady) begin
					d.resLo = q.capture.data[7:0];
					d.resHi = {q.capture.tag, q.capture.data[11:8]};
					d.con2[`SAC_C2_DONE] = 1'b1;
					d.con2[`SAC_C2_SINGLE] = 1'b0;
					d.phase = sac_pkg::SAC_IDLE;
				end
			end
			default: begin
				d.phase = sac_pkg::SAC_IDLE;
			end
		endcase

		// power down abandons a conversion in acquire or convert; a result waiting in store still completes
		if (!q.con1[`SAC_C1_POWER] && q.phase != sac_pkg::SAC_STORE) begin
			d.phase = sac_pkg::SAC_IDLE;
			d.core.trackHold = 1'b0;
			d.core.convStart = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q <= '0;
			q.con1 <= `SAC_CON1_RST;
			q.con2 <= `SAC_CON2_RST;
			q.resLo <= `SAC_RES_RST;
			q.resHi <= `SAC_RES_RST;
			q.calOfs <= FACTORY_OFFSET;
			q.calGain <= FACTORY_GAIN;
			q.phase <= sac_pkg::SAC_IDLE;
			q.pinSync <= 2'h3;
			q.pinPrev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	sac_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_DEPTH)
	) resultFifo (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inValid  (fifoInValid),
		.inData   ({q.capture.tag, q.capture.data}),
		.inReady  (fifoInReady),
		.outValid (spiValid),
		.outData  (spiData),
		.outReady (spiReady)
	);

	assign sfrRdData = q.rdData;
	assign sfrBitRdVal = q.bitRd;
	assign adcClk = q.adcClk;
	assign corePowerUp = q.core.powerUp;
	assign coreRefExternal = q.core.refExternal;
	assign coreTrackHold = q.core.trackHold;
	assign coreConvStart = q.core.convStart;
	assign coreChannel = q.core.channel;
	assign coreDacRoute = q.core.dacRoute;
	assign coreInternalSel = q.core.internalSel;
	assign coreCalOffset = q.calOfs;
	assign coreCalGain = q.calGain;
	assign conversionDone = q.con2[`SAC_C2_DONE];
endmodule

/* File: tb/sac_core_model.sv */
// behavioural analog core answering conversion starts
`timescale 1ns/10ps
module sac_core_model (
	// clock and pace
	input  wire logic        mclk,
	input  wire logic        slow,
	// control from the block
	input  wire logic        corePowerUp,
	input  wire logic        coreConvStart,
	input  wire logic [3:0]  coreChannel,
	input  wire logic [1:0]  coreDacRoute,
	// answer
	output logic             coreDone = 1'b0,
	output logic [11:0]      coreResult = 12'h000
);
	logic [5:0]  cnt = 6'h00;
	logic [11:0] val = 12'h000;
	always @(posedge mclk) begin
		coreDone <= 1'b0;
		if (coreDone)
			coreResult <= ~coreResult;
		if (cnt != 6'h00) begin
			cnt <= cnt - 6'h01;
			if (cnt == 6'h01) begin
				coreDone <= 1'b1;
				coreResult <= val;
			end
		end else if (coreConvStart && corePowerUp) begin
			cnt <= slow ? 6'h28 : 6'h02;
			val <= (|coreDacRoute) ? 12'h7E5 : {8'h9A, coreChannel};
		end
	end
endmodule

/* File: tb/sac_control_chk.sv */
// port assertions of the converter control block
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_control_chk (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// register access
	input  wire logic       sfrWrEn,
	input  wire logic [7:0] sfrAddr,
	input  wire logic [7:0] sfrWrData,
	input  wire logic       sfrBitRdEn,
	input  wire logic       sfrBitRdVal,
	// core and status
	input  wire logic       adcIntAck,
	input  wire logic       coreDone,
	input  wire logic       adcClk,
	input  wire logic       corePowerUp,
	input  wire logic       coreRefExternal,
	input  wire logic       coreTrackHold,
	input  wire logic       coreConvStart,
	input  wire logic [4:0] coreInternalSel,
	input  wire logic       conversionDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic       ck;
	logic [4:0] gap;
	logic [4:0] half;
	logic [1:0] dq;
	logic [5:0] age;
	assign half = dq == 2'h1 ? `SAC_HALF_DIV4 : dq == 2'h0 ? `SAC_HALF_DIV8 :
		dq == 2'h2 ? `SAC_HALF_DIV16 : `SAC_HALF_SPARE;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ck <= 1'b0;
			gap <= 5'h00;
			dq <= 2'h0;
			age <= 6'h00;
		end else begin
			ck <= adcClk;
			gap <= (ck != adcClk) ? 5'h00 : gap + 5'h01;
			if (sfrWrEn && sfrAddr == `SAC_ADDR_CON1) begin
				dq <= sfrWrData[5:4];
				age <= 6'h00;
			end else if (age != 6'h3F)
				age <= age + 6'h01;
		end
	end
	a_power_follow: assert property (
		sfrWrEn && sfrAddr == `SAC_ADDR_CON1 |-> ##2 corePowerUp == $past(sfrWrData[7], 2)) else $error("power bit");
	a_ref_follow: assert property (
		sfrWrEn && sfrAddr == `SAC_ADDR_CON1 |-> ##2 coreRefExternal == $past(sfrWrData[6], 2)) else $error("ref bit");
	a_start_after_hold: assert property (
		coreConvStart |-> $past(coreTrackHold) ##1 !coreConvStart) else $error("start pulse");
	a_done_sets: assert property (
		coreDone && !conversionDone |-> ##[2:40] conversionDone) else $error("done flag late");
	a_ack_clears: assert property (
		adcIntAck && !$past(coreDone) |=> !conversionDone) else $error("ack no clear");
	a_clock_alive: assert property (gap <= 5'h0F) else $error("clock stopped");
	a_clock_ratio: assert property (
		adcClk != ck && age == 6'h3F |-> gap == half) else $error("clock ratio");
	a_internal_onehot: assert property ($onehot0(coreInternalSel)) else $error("internal select");
	a_bit_idle: assert property (!$past(sfrBitRdEn) |-> !sfrBitRdVal) else $error("bit read idle");
	c_start: cover property (coreConvStart);
	c_done: cover property ($rose(conversionDone));
	c_ack: cover property (adcIntAck && conversionDone);
endmodule
bind sac_control sac_control_chk u_chk (.*);

/* File: tb/sar_adc_control_interface_bench.sv */
// register-level tests of the converter control block
`timescale 1ns/10ps
`include "sac_params.svh"
module sar_adc_control_interface_bench;
	logic        mclk = 0, rst_n = 0, slow = 0, spiReady = 0;
	logic        sfrWrEn = 0, sfrRdEn = 0, sfrBitWrEn = 0, sfrBitWrVal = 0, sfrBitRdEn = 0;
	logic        adcIntAck = 0, convertStartPin_n = 1, timerTwoOverflow = 0;
	logic [7:0]  sfrAddr = 0, sfrWrData = 0, sfrBitAddr = 0, sfrRdData, coreCalOffset, coreCalGain;
	logic [1:0]  dacEnable = 2'h1, coreDacRoute;
	logic        sfrBitRdVal, coreDone, adcClk, corePowerUp, coreRefExternal, coreTrackHold;
	logic        coreConvStart, conversionDone, spiValid;
	logic [11:0] coreResult, r;
	logic [3:0]  coreChannel;
	logic [4:0]  coreInternalSel;
	logic [15:0] spiData;
	logic [3:0]  chs [9] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'h1};
	int          failures = 0, check_count = 0, n;
	always #4 mclk = ~mclk;
	sac_control dut (.*);
	sac_core_model core (.*);
	task wt(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task chk(input string s, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [7:0] a, d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1;
		wt(1);
		sfrWrEn = 0;
		wt(1);
	endtask
	task rd(input logic [7:0] a, e);
		sfrAddr = a;
		sfrRdEn = 1;
		wt(1);
		sfrRdEn = 0;
		chk("read", {a, e}, {a, sfrRdData});
		wt(1);
	endtask
	task bwr(input logic [7:0] a, input logic v);
		sfrBitAddr = a;
		sfrBitWrVal = v;
		sfrBitWrEn = 1;
		wt(1);
		sfrBitWrEn = 0;
		wt(1);
	endtask
	task brd(input logic [7:0] a, input logic e);
		sfrBitAddr = a;
		sfrBitRdEn = 1;
		wt(1);
		sfrBitRdEn = 0;
		chk("bit", {a, 7'h0, e}, {a, 7'h0, sfrBitRdVal});
		wt(1);
	endtask
	task done(input logic e);
		n = 0;
		while (conversionDone !== 1'b1 && n < 300) begin
			wt(1);
			n++;
		end
		chk("done", {15'h0, e}, {15'h0, conversionDone});
	endtask
	task pulse_trig;
		timerTwoOverflow = 1;
		convertStartPin_n = 0;
		wt(1);
		timerTwoOverflow = 0;
		wt(15);
		convertStartPin_n = 1;
	endtask
	task reset;
		rst_n = 0;
		wt(6);
		rst_n = 1;
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#300000;
		failures++;
		wrap_up;
	end
	initial begin
		reset;
		rd(`SAC_ADDR_CON1, 8'h00);
		chk("cal", 16'h0080, {coreCalOffset, coreCalGain});
		wr(`SAC_ADDR_CAL_OFS, 8'h33);
		rd(`SAC_ADDR_CAL_OFS, 8'h33);
		reset;
		chk("cal", 16'h0080, {coreCalOffset, coreCalGain});
		wr(`SAC_ADDR_RES_LO, 8'h55);
		rd(`SAC_ADDR_RES_LO, 8'h00);
		wr(`SAC_ADDR_CON1, 8'hC0);
		wt(1);
		chk("power", 16'h0003, {14'h0, corePowerUp, coreRefExternal});
		wr(`SAC_ADDR_CON1, 8'h40);
		wt(1);
		chk("power", 16'h0001, {14'h0, corePowerUp, coreRefExternal});
		brd(8'hEE, 0);
		for (int k = 0; k < 4; k++) begin
			wr(`SAC_ADDR_CON1, {2'b10, k[1:0], 4'h0});
			wt(90);
		end
		wr(`SAC_ADDR_CON1, 8'h9C);
		foreach (chs[i]) begin
			slow = i[0];
			r = (chs[i] == 4'h4 && dacEnable[0]) ? 12'h7E5 : {8'h9A, chs[i]};
			wr(`SAC_ADDR_CON2, {4'h1, chs[i]});
			done(1);
			rd(`SAC_ADDR_RES_LO, r[7:0]);
			rd(`SAC_ADDR_RES_HI, {chs[i], r[11:8]});
			chk("internal", {11'h0, ((chs[i] >= 4'h8 && chs[i] <= 4'hC) ? 5'h01 << (chs[i] - 4'h8) : 5'h00)}, {11'h0, coreInternalSel});
			rd(`SAC_ADDR_CON2, {4'h8, chs[i]});
			bwr(8'hDF, 0);
			brd(8'hDF, 0);
		end
		slow = 0;
		wr(`SAC_ADDR_CON1, 8'h92);
		timerTwoOverflow = 1;
		wt(1);
		timerTwoOverflow = 0;
		done(1);
		adcIntAck = 1;
		wt(1);
		adcIntAck = 0;
		chk("ack", 16'h0, {15'h0, conversionDone});
		wr(`SAC_ADDR_CON1, 8'h91);
		convertStartPin_n = 0;
		wt(15);
		convertStartPin_n = 1;
		done(1);
		bwr(8'hDF, 0);
		wr(`SAC_ADDR_CON1, 8'h90);
		pulse_trig;
		done(0);
		wr(`SAC_ADDR_CON2, 8'h60);
		wt(900);
		chk("stall", 16'h1, {15'h0, spiValid});
		wr(`SAC_ADDR_CON2, 8'h40);
		spiReady = 1;
		n = 0;
		for (int k = 0; k < 100; k++) begin
			if (spiValid === 1'b1) begin
				chk("stream", 16'h09A0, spiData);
				n++;
			end
			wt(1);
		end
		chk("count", 16'h1, {15'h0, n > 16});
		wrap_up;
	end
endmodule
